/* bench/ccarr_partner.sv */
/*
 * Far-side model of the counter array: the external count pin and the five module pins.
 * Assumes the bench commands pin levels and bursts of count pulses on the system clock.
 */
`timescale 1ns/100ps
module ccarr_partner (
   input  wire logic       i_sys_clk,
   input  wire logic [4:0] i_pin_level,
   input  wire logic       i_ext_go,
   input  wire logic [3:0] i_ext_pulses,
   output logic            o_ext_count,
   output logic      [4:0] o_pins
);
   logic [3:0] left_q;
   logic [1:0] phase_q;

   // Pins move 13 ns after an edge, so the design sees truly asynchronous changes.
   always @(posedge i_sys_clk) begin
      o_pins <= #13 i_pin_level;
   end

   // Count pulses repeat every 4 cycles, the fastest rate the pin may toggle.
   // The pin stands low outside a burst.
   always @(posedge i_sys_clk) begin
      if (i_ext_go) begin
         left_q  <= i_ext_pulses;
         phase_q <= 2'h0;
      end else if (left_q != 4'h0) begin
         phase_q <= phase_q + 2'h1;
         if (phase_q == 2'h1) o_ext_count <= #13 1'b1;
         if (phase_q == 2'h3) begin
            o_ext_count <= #13 1'b0;
            left_q      <= left_q - 4'h1;
         end
      end
   end

   initial begin
      o_ext_count = 1'b0;
      o_pins      = 5'h00;
      left_q      = 4'h0;
      phase_q     = 2'h0;
   end
endmodule

/* bench/ccarr_top_tb_top.sv */
/*
 * Self-checking bench for the counter array top.
 * Assumes the partner model drives the pins and the bench drives all control bits.
 */
`timescale 1ns/100ps
module ccarr_top_tb_top;
   logic        clk, nrst, run, idles, idle, wde, ofie, t0, ofclr, go;
   logic [1:0]  sel;
   logic [3:0]  npul;
   logic [4:0]  mclr, lw, hw, lvl, gpio, pins, pout, oe, flg;
   logic [7:0]  wd;
   logic [34:0] mode;
   logic        ext, ovf, irq, wdr;
   logic [15:0] ctr, b;
   logic [39:0] vl, vh;
   int          miscompares, total_checks, cyc, wdn;

   ccarr_partner fs (.i_sys_clk(clk), .i_pin_level(lvl), .i_ext_go(go),
      .i_ext_pulses(npul), .o_ext_count(ext), .o_pins(pins));
   ccarr_top dut (.i_sys_clk(clk), .i_nrst(nrst), .i_run_control(run),
      .i_idle_stop(idles), .i_cpu_idle(idle), .i_watchdog_enable(wde),
      .i_overflow_irq_enable(ofie), .i_count_source_select(sel), .i_t0_overflow(t0),
      .i_external_count_input(ext), .i_overflow_flag_clr(ofclr),
      .i_module_event_flag_clr(mclr), .i_module_mode(mode), .i_value_low_wr(lw),
      .i_value_high_wr(hw), .i_value_wdata(wd), .i_module_io_pin(pins),
      .i_gpio_out(gpio), .o_module_io_pin(pout), .o_module_io_pin_oe(oe),
      .o_counter(ctr), .o_overflow_flag(ovf), .o_module_event_flag(flg),
      .o_module_value_low(vl), .o_module_value_high(vh), .o_irq(irq), .o_wdog_reset(wdr));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // The timeout leaves room for one full wrap of the counter.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      wdn <= wdn + int'(wdr === 1'b1);
      if (cyc == 100000) begin
         miscompares++;
         test_done;
      end
   end

   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   // Each timer-0 pulse lasts one cycle, with a gap so no two merge.
   task automatic step(input int n);
      repeat (n) begin
         @(posedge clk) t0 <= 1'b1;
         @(posedge clk) t0 <= 1'b0;
      end
      tick(3);
   endtask

   task automatic wr(input int n, input logic [7:0] lo, input logic [7:0] hi);
      @(posedge clk) begin lw <= 5'h01 << n; wd <= lo; end
      @(posedge clk) begin lw <= 5'h00; hw <= 5'h01 << n; wd <= hi; end
      @(posedge clk) hw <= 5'h00;
   endtask

   task automatic clr(input logic [4:0] m);
      @(posedge clk) mclr <= m;
      @(posedge clk) mclr <= 5'h00;
      tick(1);
   endtask

   task automatic rate(input logic [1:0] s, input logic [15:0] e);
      @(posedge clk) sel <= s;
      tick(4);
      b = ctr;
      tick(24);
      chk(ctr - b, e);
   endtask

   task automatic test_done;
      if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      {nrst, run, idles, idle, wde, ofie, t0, ofclr, go} = 9'h000;
      {sel, npul, mclr, lw, hw, lvl, gpio, wd, mode} = 0;
      {miscompares, total_checks, cyc, wdn} = 0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      tick(1);
      chk({ctr, flg, ovf, irq, oe}, {16'h0000, 5'h00, 2'b00, 5'h1f});
      // Module 1 timer, 2 hit without comparator, 3 pulse width, 4 watchdog.
      @(posedge clk) begin
         gpio <= 5'h15;
         mode <= {7'h48, 7'h44, 7'h08, 7'h49, 7'h00};
         sel <= 2'h2;
         run <= 1'b1;
         wde <= 1'b1;
      end
      wr(1, 8'h05, 8'h00);
      wr(2, 8'h05, 8'h00);
      wr(3, 8'h03, 8'h80);
      wr(4, 8'h07, 8'h00);
      step(2);
      chk({pout[3], pout[0]}, 2'b01);
      step(1);
      chk(pout[3], 1'b1);
      step(2);
      chk({ctr, flg, irq}, {16'h0005, 5'h02, 1'b1});
      clr(5'h02);
      chk({flg, irq}, 6'h00);
      step(2);
      chk({flg, wdn, irq}, {5'h10, 32'h1, 1'b0});
      // Capture: module 0 rising, 1 falling, 2 both edges.
      @(posedge clk) mode[20:0] <= {7'h30, 7'h10, 7'h20};
      clr(5'h1f);
      @(posedge clk) lvl <= 5'h07;
      tick(6);
      chk({flg, vl[23:16], vl[7:0]}, {5'h05, 8'h07, 8'h07});
      clr(5'h05);
      step(3);
      @(posedge clk) lvl <= 5'h00;
      tick(6);
      chk({flg, vl[23:8], vh[15:8]}, {5'h06, 8'h0a, 8'h0a, 8'h00});
      @(posedge clk) run <= 1'b0;
      step(3);
      chk(ctr, 16'h000a);
      @(posedge clk) run <= 1'b1;
      // Module 0 as high-speed output: the pin is claimed and flips on the match.
      @(posedge clk) mode[6:0] <= 7'h4a;
      wr(0, 8'h0c, 8'h00);
      step(2);
      chk({pout[0], flg[0]}, 2'b11);
      rate(2'h0, 16'h0004);
      rate(2'h1, 16'h000c);
      @(posedge clk) {idle, idles} <= 2'b11;
      rate(2'h1, 16'h0000);
      @(posedge clk) idles <= 1'b0;
      rate(2'h1, 16'h000c);
      @(posedge clk) begin sel <= 2'h3; go <= 1'b1; npul <= 4'h5; end
      @(posedge clk) go <= 1'b0;
      b = ctr;
      tick(30);
      chk(ctr - b, 16'h0005);
      // Hold timer-0 high until the counter wraps.
      @(posedge clk) begin sel <= 2'h2; t0 <= 1'b1; ofie <= 1'b1; wde <= 1'b0; end
      tick(2);
      while (ovf !== 1'b1) tick(1);
      chk({irq, vl[31:24]}, {1'b1, 8'h80});
      @(posedge clk) begin ofclr <= 1'b1; t0 <= 1'b0; mclr <= 5'h1f; end
      @(posedge clk) begin ofclr <= 1'b0; mclr <= 5'h00; end
      tick(2);
      chk({ovf, irq, flg}, 7'h00);
      test_done;
   end
endmodule

/* rtl/ccarr_params.svh */
/*
 * Constants for the counter array: field positions, reset values and divider counts.
 * Assumes it is included by bare name from files under rtl/.
 */
`ifndef CCARR_PARAMS_SVH
`define CCARR_PARAMS_SVH
`define CCARR_NMOD         5
`define CCARR_WDOG_MOD     4
`define CCARR_DIV6_LAST    3'h5
`define CCARR_DIV2_LAST    3'h1
`define CCARR_CNT_RST      16'h0000
`define CCARR_VAL_RST      8'h00
`define CCARR_MODE_RST     7'h00
// Mode register field positions.
`define CCARR_M_IRQ        0
`define CCARR_M_FLIP       1
`define CCARR_M_PWM        2
`define CCARR_M_HIT        3
`define CCARR_M_FALL       4
`define CCARR_M_RISE       5
`define CCARR_M_CMP        6
`endif

/* rtl/ccarr_pkg.sv */
/*
 * Types for the counter array.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ccarr_pkg;
   typedef enum logic [1:0] {
      CCARR_SRC_DIV6 = 2'h0,
      CCARR_SRC_DIV2 = 2'h1,
      CCARR_SRC_T0OV = 2'h2,
      CCARR_SRC_EXT  = 2'h3
   } ccarr_src_t;
endpackage

/* rtl/ccarr_top.sv */
/*
 * Programmable counter array: shared 16-bit time base and five compare/capture modules.
 * Assumes control bits come from a register file on the same clock, and pins are asynchronous.
 */
`timescale 1ns/100ps
`include "ccarr_params.svh"

module ccarr_top (
   input  wire logic        i_sys_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_run_control,
   input  wire logic        i_idle_stop,
   input  wire logic        i_cpu_idle,
   input  wire logic        i_watchdog_enable,
   input  wire logic        i_overflow_irq_enable,
   input  wire logic [1:0]  i_count_source_select,
   input  wire logic        i_t0_overflow,
   input  wire logic        i_external_count_input,
   input  wire logic        i_overflow_flag_clr,
   input  wire logic [4:0]  i_module_event_flag_clr,
   input  wire logic [34:0] i_module_mode,
   input  wire logic [4:0]  i_value_low_wr,
   input  wire logic [4:0]  i_value_high_wr,
   input  wire logic [7:0]  i_value_wdata,
   input  wire logic [4:0]  i_module_io_pin,
   input  wire logic [4:0]  i_gpio_out,
   output logic      [4:0]  o_module_io_pin,
   output logic      [4:0]  o_module_io_pin_oe,
   output logic      [15:0] o_counter,
   output logic             o_overflow_flag,
   output logic      [4:0]  o_module_event_flag,
   output logic      [39:0] o_module_value_low,
   output logic      [39:0] o_module_value_high,
   output logic             o_irq,
   output logic             o_wdog_reset
);

   logic [15:0] cnt_q;
   logic [2:0]  div_q;
   logic [1:0]  ext_sync_q;
   logic        ext_last_q;
   logic [4:0]  pin_s1_q;
   logic [4:0]  pin_s2_q;
   logic [4:0]  pin_last_q;
   logic        adv;
   logic        div_tick;
   logic        wrap;
   logic        ovf_q;
   logic [4:0]  flag_q;
   logic [4:0]  io_q;
   logic [7:0]  lo_q [`CCARR_NMOD];
   logic [7:0]  hi_q [`CCARR_NMOD];
   logic [4:0]  hit;
   logic [4:0]  cap;
   logic [4:0]  pwm_out;
   logic        wdog_q;
   ccarr_pkg::ccarr_src_t src;

   // Field extractor used by every module slice.
   function automatic logic mbit(input logic [34:0] m, input int n, input int f);
      mbit = m[n*7+f];
   endfunction

   assign src = ccarr_pkg::ccarr_src_t'(i_count_source_select);

   // Prescaler: the terminal count depends on the selected internal division.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         div_q <= 3'h0;
      end else if (div_tick) begin
         div_q <= 3'h0;
      end else begin
         div_q <= div_q + 3'h1;
      end
   end

   assign div_tick = (src == ccarr_pkg::CCARR_SRC_DIV6) ? (div_q >= `CCARR_DIV6_LAST)
                                                        : (div_q >= `CCARR_DIV2_LAST);

   // External pin synchroniser; edge detection reads only the second stage.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ext_sync_q <= 2'h0;
         ext_last_q <= 1'b0;
         pin_s1_q   <= 5'h00;
         pin_s2_q   <= 5'h00;
         pin_last_q <= 5'h00;
      end else begin
         ext_sync_q <= {ext_sync_q[0], i_external_count_input};
         ext_last_q <= ext_sync_q[1];
         pin_s1_q   <= i_module_io_pin;
         pin_s2_q   <= pin_s1_q;
         pin_last_q <= pin_s2_q;
      end
   end

   // Count advance: one source, gated by run control and idle stop.
   always_comb begin
      case (src)
         ccarr_pkg::CCARR_SRC_DIV6: adv = div_tick;
         ccarr_pkg::CCARR_SRC_DIV2: adv = div_tick;
         ccarr_pkg::CCARR_SRC_T0OV: adv = i_t0_overflow;
         ccarr_pkg::CCARR_SRC_EXT:  adv = ext_sync_q[1] & ~ext_last_q;
         default:                   adv = 1'b0;
      endcase
      adv = adv & i_run_control & ~(i_idle_stop & i_cpu_idle);
   end

   assign wrap = adv && (cnt_q == 16'hFFFF);

   // Shared time base, visible to every module.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q <= `CCARR_CNT_RST;
      end else if (adv) begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   // Overflow flag; a wrap in the clearing cycle keeps it set.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ovf_q <= 1'b0;
      end else if (wrap) begin
         ovf_q <= 1'b1;
      end else if (i_overflow_flag_clr) begin
         ovf_q <= 1'b0;
      end
   end

   // Per-module compare, capture and pwm decode.
   genvar g;
   generate
      for (g = 0; g < `CCARR_NMOD; g++) begin : g_mod
         logic cmp_en;
         logic rise;
         logic fall;
         logic claim;
         assign cmp_en = mbit(i_module_mode, g, `CCARR_M_CMP);
         // Comparing on the advance cycle makes each count value match once only.
         assign hit[g] = cmp_en && adv && (cnt_q + 16'h0001 == {hi_q[g], lo_q[g]});
         assign rise = pin_s2_q[g] & ~pin_last_q[g];
         assign fall = ~pin_s2_q[g] & pin_last_q[g];
         assign cap[g] = (rise & mbit(i_module_mode, g, `CCARR_M_RISE))
                       | (fall & mbit(i_module_mode, g, `CCARR_M_FALL));
         assign pwm_out[g] = (cnt_q[7:0] >= lo_q[g]);

         // Value registers: capture wins over software writes.
         always_ff @(posedge i_sys_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               lo_q[g] <= `CCARR_VAL_RST;
               hi_q[g] <= `CCARR_VAL_RST;
            end else if (cap[g]) begin
               lo_q[g] <= cnt_q[7:0];
               hi_q[g] <= cnt_q[15:8];
            end else begin
               if (mbit(i_module_mode, g, `CCARR_M_PWM) && cmp_en && wrap_low()) begin
                  lo_q[g] <= hi_q[g];
               end else if (i_value_low_wr[g]) begin
                  lo_q[g] <= i_value_wdata;
               end
               if (i_value_high_wr[g]) begin
                  hi_q[g] <= i_value_wdata;
               end
            end
         end

         // Event flag: hardware set wins over software clear.
         always_ff @(posedge i_sys_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               flag_q[g] <= 1'b0;
            end else if ((hit[g] && mbit(i_module_mode, g, `CCARR_M_HIT)) || cap[g]) begin
               flag_q[g] <= 1'b1;
            end else if (i_module_event_flag_clr[g]) begin
               flag_q[g] <= 1'b0;
            end
         end

         // Toggle output for high-speed mode.
         always_ff @(posedge i_sys_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               io_q[g] <= 1'b0;
            end else if (mbit(i_module_mode, g, `CCARR_M_PWM) && cmp_en) begin
               io_q[g] <= pwm_out[g];
            end else if (hit[g] && mbit(i_module_mode, g, `CCARR_M_FLIP)
                         && mbit(i_module_mode, g, `CCARR_M_HIT)) begin
               io_q[g] <= ~io_q[g];
            end
         end

         // The array claims the pin only in toggle or pwm modes; else ordinary I/O.
         assign claim = cmp_en && (mbit(i_module_mode, g, `CCARR_M_PWM)
                        || (mbit(i_module_mode, g, `CCARR_M_FLIP)
                        && mbit(i_module_mode, g, `CCARR_M_HIT)));
         assign o_module_io_pin[g] = claim ? io_q[g] : i_gpio_out[g];
         assign o_module_io_pin_oe[g] = 1'b1;
      end
   endgenerate

   // Low byte wraps from FF to 00 on this advance.
   function automatic logic wrap_low();
      wrap_low = adv && (cnt_q[7:0] == 8'hFF);
   endfunction

   // Watchdog reset pulse on module 4 match while enabled.
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wdog_q <= 1'b0;
      end else begin
         wdog_q <= i_watchdog_enable && hit[`CCARR_WDOG_MOD];
      end
   end

   // Output assembly.
   always_comb begin
      o_irq = ovf_q & i_overflow_irq_enable;
      for (int n = 0; n < `CCARR_NMOD; n++) begin
         o_irq = o_irq | (flag_q[n] & mbit(i_module_mode, n, `CCARR_M_IRQ));
         o_module_value_low[n*8 +: 8]  = lo_q[n];
         o_module_value_high[n*8 +: 8] = hi_q[n];
      end
   end

   assign o_counter           = cnt_q;
   assign o_overflow_flag     = ovf_q;
   assign o_module_event_flag = flag_q;
   assign o_wdog_reset        = wdog_q;

   // Checks kept beside the logic.
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);

   sequence s_wrap;
      adv && (cnt_q == 16'hFFFF);
   endsequence

   run_gate_a: assert property (!i_run_control |=> $stable(cnt_q))
      else $error("counter moved with run control clear");
   idle_stop_a: assert property (i_idle_stop && i_cpu_idle |=> $stable(cnt_q))
      else $error("counter moved in idle with idle stop");
   wrap_zero_a: assert property (s_wrap |=> cnt_q == 16'h0000 && ovf_q)
      else $error("wrap did not reach zero with overflow");
   ovf_sticky_a: assert property (ovf_q && !i_overflow_flag_clr |=> ovf_q)
      else $error("overflow flag dropped without clear");
   div6_rate_a: assert property (disable iff (!i_nrst || src != ccarr_pkg::CCARR_SRC_DIV6)
      src == ccarr_pkg::CCARR_SRC_DIV6 && div_q == 3'h0
      && $past(div_tick) |-> !div_tick [*5] ##1 div_tick)
      else $error("clock six divider period wrong");
   capture_copy_a: assert property (cap[0] |=> {hi_q[0], lo_q[0]} == $past(cnt_q) && flag_q[0])
      else $error("capture did not copy counter");
   irq_gate_a: assert property (flag_q[1] && i_module_mode[`CCARR_M_IRQ + 7] |-> o_irq)
      else $error("enabled module flag not on irq");
   wdog_pulse_a: assert property (hit[4] && i_watchdog_enable |=> o_wdog_reset)
      else $error("watchdog match gave no reset");
   fast_toggle_a: assert property (hit[0] && i_module_mode[`CCARR_M_FLIP]
      && i_module_mode[`CCARR_M_HIT] && !i_module_mode[`CCARR_M_PWM]
      |=> io_q[0] != $past(io_q[0]))
      else $error("toggle output did not flip on match");
   pwm_level_a: assert property (i_module_mode[`CCARR_M_PWM + 21]
      && i_module_mode[`CCARR_M_CMP + 21] |=> io_q[3] == $past(pwm_out[3]))
      else $error("pwm level wrong");

endmodule
